//--- rtl/pvi_ctrl.sv
`timescale 1ns/10ps
module pvi_ctrl (
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    input  wire logic [pvi_pkg::NUM_IRQ-1:0]  request_inputs,
    input  wire logic [7:0]                   io_addr,
    input  wire logic                         io_wr,
    input  wire logic                         io_rd,
    input  wire logic [7:0]                   io_wdata,
    output logic      [7:0]                   io_rdata,
    output logic                              cpu_irq_n,
    input  wire logic                         cpu_acknowledge_n,
    output logic      [7:0]                   cpu_data_out,
    output logic                              cpu_data_oe,
    input  wire logic                         service_done_n
);
    import pvi_pkg::*;

    logic                rst_q1_r;
    logic                rst_n;
    logic [NUM_IRQ-1:0]  req_q1_r;
    logic [NUM_IRQ-1:0]  req_s_r;
    logic [NUM_IRQ-1:0]  req_d_r;
    logic [NUM_IRQ-1:0]  pending_requests_r;
    logic [NUM_IRQ-1:0]  pending_nxt;
    logic [NUM_IRQ-1:0]  in_service_status_r;
    logic [NUM_IRQ-1:0]  in_service_nxt;
    logic [NUM_IRQ-1:0]  trigger_mode_select_r;
    logic [NUM_IRQ-1:0]  priority_group_select_r;
    logic [NUM_IRQ-1:0]  request_mask_r;
    logic [2:0]          vector_upper_bits_r;
    logic                vec_set_r;
    logic                illegal_r;
    logic                ack_d_r;
    logic                done_d_r;
    logic [7:0]          vector_r;
    logic                oe_r;
    logic [7:0]          io_rdata_r;

    // Reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_q1_r <= 1'b1;
            rst_n    <= rst_q1_r;
        end
    end

    // Request pins come from other domains
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q1_r <= ZERO_RST;
            req_s_r  <= ZERO_RST;
            req_d_r  <= ZERO_RST;
        end else begin
            req_q1_r <= request_inputs;
            req_s_r  <= req_q1_r;
            req_d_r  <= req_s_r;
        end
    end

    wire [NUM_IRQ-1:0] rise_w = req_s_r & ~req_d_r;
    wire               ack_fall  = ~cpu_acknowledge_n & ack_d_r;
    wire               done_fall = ~service_done_n & done_d_r;

    // Candidate and in-service winners
    wire [NUM_IRQ-1:0] elig_w = pending_requests_r & ~request_mask_r;
    logic              elig_found;
    logic [IDX_W-1:0]  elig_idx;
    logic [RANK_W-1:0] elig_rank;
    logic              isr_found;
    logic [IDX_W-1:0]  isr_idx;
    logic [RANK_W-1:0] isr_rank;

    pvi_prio u_elig (
        .req   (elig_w),
        .grp   (priority_group_select_r),
        .found (elig_found),
        .idx   (elig_idx),
        .rank  (elig_rank)
    );

    pvi_prio u_isr (
        .req   (in_service_status_r),
        .grp   (priority_group_select_r),
        .found (isr_found),
        .idx   (isr_idx),
        .rank  (isr_rank)
    );

    // Only strictly higher than the deepest service level nests
    wire want_w = elig_found && (!isr_found || elig_rank > isr_rank)
                  && !illegal_r;
    assign cpu_irq_n = ~want_w;

    wire legal_ack   = ack_fall & want_w;
    wire illegal_ack = ack_fall & ~want_w & ~illegal_r;
    wire done_normal = done_fall & ~illegal_r;

    wire [NUM_IRQ-1:0] set_oh = legal_ack ? (NUM_IRQ'(1) << elig_idx)
                                          : ZERO_RST;
    wire [NUM_IRQ-1:0] clr_oh = (done_normal && isr_found)
                                ? (NUM_IRQ'(1) << isr_idx) : ZERO_RST;

    // Vector: top bits, index, bit zero low
    wire [7:0] vec_w = {vector_upper_bits_r,
                        legal_ack ? elig_idx : IDX_ZERO, 1'b0};

    // Edge: latch until accepted, new edge beats clear; level: follow
    assign pending_nxt = (trigger_mode_select_r
                          & ((pending_requests_r & ~set_oh) | rise_w))
                       | (~trigger_mode_select_r & req_s_r);
    assign in_service_nxt = (in_service_status_r | set_oh) & ~clr_oh;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_requests_r  <= ZERO_RST;
            in_service_status_r <= ZERO_RST;
            illegal_r           <= 1'b0;
            ack_d_r             <= 1'b1;
            done_d_r            <= 1'b1;
        end else begin
            pending_requests_r  <= pending_nxt;
            in_service_status_r <= in_service_nxt;
            ack_d_r             <= cpu_acknowledge_n;
            done_d_r            <= service_done_n;
            if (illegal_ack)
                illegal_r <= 1'b1;
            else if (done_fall)
                illegal_r <= 1'b0;
        end
    end

    // Vector drive while the acknowledge stays low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_r <= BYTE_ZERO;
            oe_r     <= 1'b0;
        end else begin
            if (ack_fall)
                vector_r <= vec_w;
            oe_r <= ack_fall | (oe_r & ~cpu_acknowledge_n);
        end
    end

    assign cpu_data_out = vector_r;
    assign cpu_data_oe  = oe_r & ~cpu_acknowledge_n;

    // Register port; the vector-written flag steers 34H-36H writes
    wire wr_lo = io_wr && io_addr == ADDR_LO_34;
    wire wr_hi = io_wr && io_addr == ADDR_HI_35;
    wire wr_ml = io_wr && io_addr == ADDR_MASK_LO;
    wire wr_mh = io_wr && io_addr == ADDR_MASK_HI;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_mode_select_r   <= ZERO_RST;
            priority_group_select_r <= ZERO_RST;
            request_mask_r          <= MASK_RST;
            vector_upper_bits_r     <= VEC_TOP_RST;
            vec_set_r               <= 1'b0;
        end else begin
            if (wr_lo && !vec_set_r)
                trigger_mode_select_r[7:0] <= io_wdata;
            if (wr_hi && !vec_set_r)
                trigger_mode_select_r[15:8] <= io_wdata;
            if (wr_lo && vec_set_r)
                priority_group_select_r[7:0] <= io_wdata;
            if (wr_hi && vec_set_r)
                priority_group_select_r[15:8] <= io_wdata;
            if (wr_ml && !vec_set_r) begin
                vector_upper_bits_r <= io_wdata[7:VEC_TOP_LSB];
                vec_set_r           <= 1'b1;
            end
            if (wr_ml && vec_set_r)
                request_mask_r[7:0] <= io_wdata;
            if (wr_mh)
                request_mask_r[15:8] <= io_wdata;
        end
    end

    // Reads are answered one clock after the strobe
    wire [7:0] rd_mux =
        io_addr == ADDR_LO_34   ? in_service_status_r[7:0]  :
        io_addr == ADDR_HI_35   ? in_service_status_r[15:8] :
        io_addr == ADDR_MASK_LO ? request_mask_r[7:0]       :
        io_addr == ADDR_MASK_HI ? request_mask_r[15:8]      : BYTE_ZERO;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            io_rdata_r <= BYTE_ZERO;
        else if (io_rd)
            io_rdata_r <= rd_mux;
    end

    assign io_rdata = io_rdata_r;

    a_irq_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !cpu_irq_n |-> elig_found && !illegal_r
                       && (!isr_found || elig_rank > isr_rank))
        else $error("request raised without a qualifying input");

    a_mask_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        request_mask_r == MASK_RST |-> cpu_irq_n)
        else $error("request raised with all inputs masked");

    a_vec_format: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_data_oe |-> cpu_data_out[0] == 1'b0
                        && cpu_data_out[7:5] == vector_upper_bits_r)
        else $error("vector format wrong");

    a_isr_on_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
        legal_ack |=> in_service_status_r[cpu_data_out[4:1]]
                      && cpu_data_oe == !cpu_acknowledge_n)
        else $error("acknowledged input not in service");

    a_illegal_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
        illegal_ack |=> illegal_r && cpu_data_out[4:1] == IDX_ZERO
                        && $stable(in_service_status_r))
        else $error("illegal acknowledge handled wrongly");

    a_illegal_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        illegal_r |-> cpu_irq_n)
        else $error("request raised in illegal state");

    a_illegal_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        illegal_r && done_fall && !ack_fall |=> !illegal_r
                                   && $stable(in_service_status_r))
        else $error("illegal state end touched in-service bits");

    a_done_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done_normal && isr_found && !ack_fall
            |=> !in_service_status_r[$past(isr_idx)])
        else $error("end of service did not clear bit");

    a_edge_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rise_w & trigger_mode_select_r) != ZERO_RST && !ack_fall
            |=> ($past(rise_w & trigger_mode_select_r)
                 & ~pending_requests_r) == ZERO_RST)
        else $error("edge request not latched");

    a_level_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (($past(req_s_r) ^ pending_requests_r)
             & $past(~trigger_mode_select_r)) == ZERO_RST)
        else $error("level pending does not follow input");
endmodule

//--- rtl/pvi_pkg.sv
package pvi_pkg;
    localparam int          NUM_IRQ      = 16;
    localparam int          IDX_W        = 4;
    localparam int          RANK_W       = 5;
    localparam logic [7:0]  ADDR_LO_34   = 8'h34;
    localparam logic [7:0]  ADDR_HI_35   = 8'h35;
    localparam logic [7:0]  ADDR_MASK_LO = 8'h36;
    localparam logic [7:0]  ADDR_MASK_HI = 8'h37;
    localparam int          VEC_TOP_LSB  = 5;
    localparam logic [15:0] MASK_RST     = 16'hFFFF;
    localparam logic [15:0] ZERO_RST     = 16'h0000;
    localparam logic [2:0]  VEC_TOP_RST  = 3'h0;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [3:0]  IDX_ZERO     = 4'h0;
endpackage

//--- rtl/pvi_prio.sv
`timescale 1ns/10ps
// Picks the highest ranked set bit; rank is {group, index}
module pvi_prio (
    input  wire logic [pvi_pkg::NUM_IRQ-1:0] req,
    input  wire logic [pvi_pkg::NUM_IRQ-1:0] grp,
    output logic                             found,
    output logic [pvi_pkg::IDX_W-1:0]        idx,
    output logic [pvi_pkg::RANK_W-1:0]       rank
);
    import pvi_pkg::*;

    always_comb begin
        found = 1'b0;
        idx   = IDX_ZERO;
        rank  = {1'b0, IDX_ZERO};
        // Ascending scan with >= lets the higher index win ties
        for (int i = 0; i < NUM_IRQ; i++) begin
            if (req[i] && (!found || {grp[i], IDX_W'(i)} >= rank)) begin
                found = 1'b1;
                idx   = IDX_W'(i);
                rank  = {grp[i], IDX_W'(i)};
            end
        end
    end
endmodule

//--- testbench/pvi_cpu_model.sv
`timescale 1ns/10ps
module pvi_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] cpu_data_out,
    input  wire logic       cpu_data_oe,
    output logic            cpu_acknowledge_n,
    output logic            service_done_n
);
    initial begin
        cpu_acknowledge_n = 1'b1;
        service_done_n    = 1'b1;
    end
    // Holds acknowledge until the vector shows, as a mode-2 core does
    task automatic take_vector(input int lag, output logic [7:0] vec);
        int n;
        n = 0;
        repeat (lag) @(posedge ref_clk);
        #1 cpu_acknowledge_n = 1'b0;
        // Look just after the edge so the registered enable has settled
        do begin
            @(posedge ref_clk);
            #1 n++;
        end while (cpu_data_oe !== 1'b1 && n < 20);
        vec = cpu_data_out;
        cpu_acknowledge_n = 1'b1;
    endtask
    // Return instruction strobe, one cycle low
    task automatic end_service();
        @(posedge ref_clk);
        #1 service_done_n = 1'b0;
        @(posedge ref_clk);
        #1 service_done_n = 1'b1;
    endtask
endmodule

//--- testbench/priority_vectored_interrupt_ctrl_bench.sv
`timescale 1ns/10ps
module priority_vectored_interrupt_ctrl_bench;
    typedef struct {
        logic [15:0] grp;
        logic [15:0] req;
        logic [3:0]  idx;
    } pvi_row_s;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] request_inputs = 16'h0000;
    logic [7:0]  io_addr = 8'h00;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  io_rdata;
    logic        cpu_irq_n;
    logic        ack_n;
    logic [7:0]  cpu_data_out;
    logic        cpu_data_oe;
    logic        done_n;
    logic [7:0]  b;
    logic [15:0] w;
    int          failures = 0;
    int          comparisons = 0;
    pvi_row_s    rows [3] = '{'{16'h0000, 16'h8001, 4'hF},
                              '{16'h0001, 16'h8001, 4'h0},
                              '{16'h1597, 16'h8080, 4'h7}};
    pvi_ctrl u_pvi_ctrl (.ref_clk(ref_clk), .reset_n(reset_n),
        .request_inputs(request_inputs), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .cpu_irq_n(cpu_irq_n), .cpu_acknowledge_n(ack_n),
        .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
        .service_done_n(done_n));
    pvi_cpu_model u_pvi_cpu_model (.ref_clk(ref_clk),
        .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
        .cpu_acknowledge_n(ack_n), .service_done_n(done_n));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge ref_clk);
        #1 io_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1 io_addr = a;
        io_rd = 1'b1;
        @(posedge ref_clk);
        #1 io_rd = 1'b0;
        @(posedge ref_clk);
        #2 d = io_rdata;
    endtask
    task automatic rd_isr(input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(8'h34, lo);
        rd(8'h35, hi);
        chk("in_service", e, {hi, lo});
    endtask
    task automatic irq_is(input logic lvl, input int span);
        int n;
        n = 0;
        while (cpu_irq_n !== lvl && n < span) begin
            @(posedge ref_clk);
            #2 n++;
        end
        chk("irq_n", {15'h0, lvl}, {15'h0, cpu_irq_n});
    endtask
    task automatic serve(input logic [3:0] idx, input logic [15:0] in_service_status);
        logic [7:0] v;
        irq_is(1'b0, 30);
        u_pvi_cpu_model.take_vector(1, v);
        chk("vector", {8'h0, 3'h5, idx, 1'b0}, {8'h0, v});
        rd_isr(in_service_status);
    endtask
    initial begin
        #(20 * 4000);
        failures++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(8'h36, b);
        chk("mask_lo", 16'h00FF, {8'h0, b});
        rd(8'h37, b);
        chk("mask_hi", 16'h00FF, {8'h0, b});
        rd_isr(16'h0000);
        irq_is(1'b1, 0);
        wr(8'h34, 8'h02);
        wr(8'h35, 8'h00);
        wr(8'h36, 8'hA0);
        wr(8'h36, 8'h00);
        wr(8'h37, 8'h00);
        foreach (rows[i]) begin
            wr(8'h34, rows[i].grp[7:0]);
            wr(8'h35, rows[i].grp[15:8]);
            #1 request_inputs = rows[i].req;
            serve(rows[i].idx, 16'h1 << rows[i].idx);
            request_inputs = 16'h0000;
            u_pvi_cpu_model.end_service();
            rd_isr(16'h0000);
        end
        wr(8'h34, 8'h00);
        wr(8'h35, 8'h00);
        request_inputs = 16'h0008;
        serve(4'h3, 16'h0008);
        request_inputs = 16'h000C;
        irq_is(1'b1, 0);
        repeat (8) @(posedge ref_clk);
        irq_is(1'b1, 0);
        request_inputs = 16'h020C;
        serve(4'h9, 16'h0208);
        // Input nine must go away, or it would rightly ask again
        request_inputs = 16'h000C;
        u_pvi_cpu_model.end_service();
        rd_isr(16'h0008);
        irq_is(1'b1, 0);
        request_inputs = 16'h0004;
        u_pvi_cpu_model.end_service();
        serve(4'h2, 16'h0004);
        u_pvi_cpu_model.end_service();
        request_inputs = 16'h0000;
        repeat (6) @(posedge ref_clk);
        u_pvi_cpu_model.take_vector(0, b);
        chk("illegal_vec", 16'h00A0, {8'h0, b});
        rd_isr(16'h0000);
        rd(8'h34, b);
        chk("isr_bit0", 16'h0000, {15'h0, b[0]});
        request_inputs = 16'h0020;
        repeat (8) @(posedge ref_clk);
        irq_is(1'b1, 0);
        u_pvi_cpu_model.end_service();
        serve(4'h5, 16'h0020);
        request_inputs = 16'h0002;
        u_pvi_cpu_model.end_service();
        repeat (3) @(posedge ref_clk);
        #1 request_inputs = 16'h0000;
        serve(4'h1, 16'h0002);
        u_pvi_cpu_model.end_service();
        repeat (6) @(posedge ref_clk);
        irq_is(1'b1, 0);
        wr(8'h36, 8'h10);
        #1 request_inputs = 16'h0010;
        repeat (8) @(posedge ref_clk);
        irq_is(1'b1, 0);
        rd(8'h36, b);
        chk("mask_lo", 16'h0010, {8'h0, b});
        rd(8'h40, b);
        chk("unmapped", 16'h0000, {8'h0, b});
        conclude();
    end
endmodule
